//--- core/cpw_pkg.sv
/*
  Constants, types and timing counts for the card command executor.
  Assumes a 50 MHz system clock and the task-file register map below.
*/
`default_nettype none
package cpw_pkg;
  // ***********************************************
  // Task-file register offsets
  // ***********************************************
  localparam logic [2:0] A_DATA     = 3'h0;
  localparam logic [2:0] A_ERR_FEAT = 3'h1;
  localparam logic [2:0] A_SECCNT   = 3'h2;
  localparam logic [2:0] A_SECNUM   = 3'h3;
  localparam logic [2:0] A_CYLLO    = 3'h4;
  localparam logic [2:0] A_CYLHI    = 3'h5;
  localparam logic [2:0] A_DRVHD    = 3'h6;
  localparam logic [2:0] A_CMD_STAT = 3'h7;

  // ***********************************************
  // Command opcodes and feature codes
  // ***********************************************
  localparam logic [7:0] CMD_SLEEP_A   = 8'h99;
  localparam logic [7:0] CMD_SLEEP_B   = 8'he6;
  localparam logic [7:0] CMD_STBY_A    = 8'h96;
  localparam logic [7:0] CMD_STBY_B    = 8'he2;
  localparam logic [7:0] CMD_STBY_C    = 8'h94;
  localparam logic [7:0] CMD_STBY_D    = 8'he0;
  localparam logic [7:0] CMD_TRANSLATE = 8'h87;
  localparam logic [7:0] CMD_WEAR      = 8'hf5;
  localparam logic [7:0] CMD_WRBUF     = 8'he8;
  localparam logic [7:0] CMD_WRDMA     = 8'hca;
  localparam logic [7:0] CMD_SETFEAT   = 8'hef;
  localparam logic [7:0] FEAT_BYTE_ON  = 8'h01;
  localparam logic [7:0] FEAT_BYTE_OFF = 8'h81;

  // ***********************************************
  // Status and error bit positions
  // ***********************************************
  localparam int ST_BSY   = 7;
  localparam int ST_DRDY  = 6;
  localparam int ST_DRQ   = 3;
  localparam int ST_ERR   = 0;
  localparam int ER_ABRT  = 2;
  localparam int ER_MEDIA = 6;

  // ***********************************************
  // Translate buffer layout
  // ***********************************************
  localparam logic [8:0] TR_CYL_MSB = 9'h000;
  localparam logic [8:0] TR_CYL_LSB = 9'h001;
  localparam logic [8:0] TR_HEAD    = 9'h002;
  localparam logic [8:0] TR_SECT    = 9'h003;
  localparam logic [8:0] TR_LBA_MSB = 9'h004;
  localparam logic [8:0] TR_LBA_MID = 9'h005;
  localparam logic [8:0] TR_LBA_LSB = 9'h006;
  localparam logic [8:0] TR_ERASED  = 9'h013;
  localparam logic [8:0] TR_HOT_MSB = 9'h018;
  localparam logic [8:0] TR_HOT_MID = 9'h019;
  localparam logic [8:0] TR_HOT_LSB = 9'h01a;
  localparam logic [8:0] TR_LAST_B  = 9'h1ff;
  localparam logic [8:0] TR_LAST_W  = 9'h1fe;
  localparam logic [7:0] ERASED_YES = 8'hff;
  localparam logic [7:0] ERASED_NO  = 8'h00;
  localparam logic [7:0] WEAR_NONE  = 8'h00;

  // ***********************************************
  // Sizes, reset values, timing
  // ***********************************************
  localparam logic [7:0] LAST_WORD   = 8'hff;
  localparam logic [8:0] FULL_COUNT  = 9'h100;
  localparam logic [7:0] RST_SECCNT  = 8'h01;
  localparam logic [7:0] RST_SECNUM  = 8'h01;
  localparam int unsigned CLK_HZ        = 50000000;
  localparam int unsigned SLEEP_TIME_MS = 5;
  localparam int unsigned SLEEP_CYCLES  = CLK_HZ / 1000 * SLEEP_TIME_MS;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] sec_cnt;
    logic [7:0] sec_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] drv_hd;
  } cpw_taskfile_s;

  typedef struct packed {
    logic        req;
    logic [27:0] lba;
  } cpw_prog_s;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_PREP    = 3'h1,
    ST_XFER    = 3'h3,
    ST_PROG    = 3'h2,
    ST_DONE    = 3'h6,
    ST_PIO_IN  = 3'h7,
    ST_PIO_OUT = 3'h5
  } cpw_state_e;
endpackage
`default_nettype wire

//--- core/cpw_core.sv
/*
  Command executor for sleep, standby, translate, wear level, write buffer
  and DMA write. Assumes bus, DMA and media inputs synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE1 - Sleep opcode: set busy, sleep, clear busy, raise interrupt.
// RULE2 - Any later command wakes from sleep; reset also wakes.
// RULE3 - Idle timer of five milliseconds puts the card to sleep.
// RULE4 - Standby opcodes: busy, sleep, clear busy, interrupt at once.
// RULE5 - Translate returns a 512-byte buffer describing the addressed sector.
// RULE6 - Bytes 0-1 cylinder, 2 head, 3 sector, 4-6 LBA, MSB first.
// RULE7 - Byte 0x13 reads all ones when erased, zero otherwise.
// RULE8 - Bytes 0x18-0x1a hold wear cycle count, MSB first.
// RULE9 - Wear count of zero means counting is unsupported.
// RULE10 - Without security, wear level only returns zero sector count.
// RULE11 - With security, wear level acts as freeze lock.
// RULE12 - Write buffer takes 512 bytes into sector buffer like PIO write.
// RULE13 - DMA write moves 1 to 256 sectors; count zero means 256.
// RULE14 - DMA write sets busy, then data request and clears busy.
// RULE15 - DMAREQ stays high while the card can accept data.
// RULE16 - Host acknowledges and strobes one write per 16-bit word.
// RULE17 - DMA write interrupts only at completion or on error.
// RULE18 - On success address registers hold the last sector processed.
// RULE19 - On error stop at failing sector, keep its address.
// RULE20 - DMA write in byte mode is aborted.
// RULE21 - Feature 01h enables, 81h disables byte-wide transfers.
// RULE22 - Reserved translate bytes read as zero.
module cpw_core #(
  parameter int unsigned SLEEP_CYCLES = cpw_pkg::SLEEP_CYCLES,
  parameter bit          SECURITY     = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        we,
  input  wire logic        re,
  output logic      [15:0] rdata,
  output logic             intrq,
  output logic             dmareq,
  input  wire logic        dmack_n,
  input  wire logic        iowr_n,
  input  wire logic [15:0] dma_data,
  output logic             sleeping,
  output logic             frozen,
  output cpw_pkg::cpw_prog_s prog,
  input  wire logic        prog_done,
  input  wire logic        prog_err,
  input  wire logic [7:0]  buf_idx,
  output logic      [15:0] buf_word,
  input  wire logic        erased,
  input  wire logic [23:0] hot_count
);
  // ***********************************************
  // Helpers
  // ***********************************************
  function automatic logic is_sleep(input logic [7:0] c);
    return c == cpw_pkg::CMD_SLEEP_A || c == cpw_pkg::CMD_SLEEP_B;
  endfunction

  function automatic logic is_stby(input logic [7:0] c);
    return c == cpw_pkg::CMD_STBY_A || c == cpw_pkg::CMD_STBY_B ||
           c == cpw_pkg::CMD_STBY_C || c == cpw_pkg::CMD_STBY_D;
  endfunction

  function automatic logic [7:0] tr_byte(input logic [8:0] idx,
                                         input cpw_pkg::cpw_taskfile_s t,
                                         input logic er,
                                         input logic [23:0] hc);
    logic [7:0] b;
    b = 8'h00; // [RULE22]
    case (idx) // [RULE5] [RULE6]
      cpw_pkg::TR_CYL_MSB: b = t.cyl_hi;
      cpw_pkg::TR_CYL_LSB: b = t.cyl_lo;
      cpw_pkg::TR_HEAD:    b = {4'h0, t.drv_hd[3:0]};
      cpw_pkg::TR_SECT:    b = t.sec_num;
      cpw_pkg::TR_LBA_MSB: b = t.cyl_hi;
      cpw_pkg::TR_LBA_MID: b = t.cyl_lo;
      cpw_pkg::TR_LBA_LSB: b = t.sec_num;
      cpw_pkg::TR_ERASED:  b = er ? cpw_pkg::ERASED_YES : cpw_pkg::ERASED_NO; // [RULE7]
      // A zero count from the media side tells the host counting is absent
      cpw_pkg::TR_HOT_MSB: b = hc[23:16]; // [RULE8] [RULE9]
      cpw_pkg::TR_HOT_MID: b = hc[15:8];
      cpw_pkg::TR_HOT_LSB: b = hc[7:0];
      default:             b = 8'h00;
    endcase
    return b;
  endfunction

  // ***********************************************
  // State and decode
  // ***********************************************
  cpw_pkg::cpw_state_e    state;
  cpw_pkg::cpw_taskfile_s tf;
  logic [7:0]  cmd;
  logic [7:0]  err_reg;
  logic        byte_mode;
  logic [15:0] sbuf [0:255];
  logic [7:0]  widx;
  logic [8:0]  bptr;
  logic        lo_pend;
  logic [7:0]  lo_byte;
  logic [8:0]  remaining;
  logic        iowr_q;
  logic [19:0] idle_cnt;
  logic [27:0] lba;
  logic [27:0] next_lba;
  logic        busy;
  logic        drq;
  logic        cmd_wr;
  logic        tf_wr;
  logic        pio_wr;
  logic        pio_rd;
  logic        pio_word;
  logic        dma_stb;
  logic        store;
  logic        timer_hit;
  logic        abort;
  logic [15:0] store_word;
  logic [7:0]  status;

  assign lba      = {tf.drv_hd[3:0], tf.cyl_hi, tf.cyl_lo, tf.sec_num};
  assign next_lba = lba + 28'h1;
  assign busy     = state == cpw_pkg::ST_PREP || state == cpw_pkg::ST_PROG ||
                    state == cpw_pkg::ST_DONE;
  assign drq      = state == cpw_pkg::ST_PIO_IN || state == cpw_pkg::ST_PIO_OUT ||
                    state == cpw_pkg::ST_XFER;
  // Commands and task-file writes are ignored unless the card is idle
  assign cmd_wr   = we && addr == cpw_pkg::A_CMD_STAT && state == cpw_pkg::ST_IDLE;
  assign tf_wr    = we && state == cpw_pkg::ST_IDLE;
  assign pio_wr   = we && addr == cpw_pkg::A_DATA && state == cpw_pkg::ST_PIO_IN;
  assign pio_rd   = re && addr == cpw_pkg::A_DATA && state == cpw_pkg::ST_PIO_OUT;
  assign pio_word = pio_wr && (!byte_mode || lo_pend);
  // One word per falling write strobe while acknowledged [RULE16]
  assign dma_stb  = state == cpw_pkg::ST_XFER && !dmack_n && iowr_q && !iowr_n;
  assign store    = pio_word || dma_stb;
  assign store_word = dma_stb ? dma_data : (byte_mode ? {wdata[7:0], lo_byte} : wdata);
  assign timer_hit = idle_cnt == 20'(SLEEP_CYCLES - 1);
  assign abort    = (cmd == cpw_pkg::CMD_WRDMA && byte_mode) || // [RULE20]
                    !(is_sleep(cmd) || is_stby(cmd) || cmd == cpw_pkg::CMD_TRANSLATE ||
                      cmd == cpw_pkg::CMD_WEAR || cmd == cpw_pkg::CMD_WRBUF ||
                      cmd == cpw_pkg::CMD_WRDMA || cmd == cpw_pkg::CMD_SETFEAT);
  // Request held only while the buffer has room [RULE15]
  assign dmareq   = state == cpw_pkg::ST_XFER;

  always_comb begin
    status = 8'h00;
    status[cpw_pkg::ST_BSY]  = busy;
    status[cpw_pkg::ST_DRDY] = 1'b1;
    status[cpw_pkg::ST_DRQ]  = drq;
    status[cpw_pkg::ST_ERR]  = err_reg != 8'h00;
  end

  // ***********************************************
  // Command sequencer
  // ***********************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= cpw_pkg::ST_IDLE;
    end else begin
      case (state)
        cpw_pkg::ST_IDLE: begin
          if (cmd_wr) begin
            state <= cpw_pkg::ST_PREP;
          end
        end
        cpw_pkg::ST_PREP: begin
          if (abort) begin
            state <= cpw_pkg::ST_DONE;
          end else if (cmd == cpw_pkg::CMD_TRANSLATE) begin
            state <= cpw_pkg::ST_PIO_OUT;
          end else if (cmd == cpw_pkg::CMD_WRBUF) begin
            state <= cpw_pkg::ST_PIO_IN; // [RULE12]
          end else if (cmd == cpw_pkg::CMD_WRDMA) begin
            state <= cpw_pkg::ST_XFER; // [RULE14]
          end else begin
            state <= cpw_pkg::ST_DONE; // [RULE1] [RULE4]
          end
        end
        cpw_pkg::ST_PIO_IN: begin
          if (pio_word && widx == cpw_pkg::LAST_WORD) begin
            state <= cpw_pkg::ST_DONE;
          end
        end
        cpw_pkg::ST_PIO_OUT: begin
          if (pio_rd && bptr == (byte_mode ? cpw_pkg::TR_LAST_B : cpw_pkg::TR_LAST_W)) begin
            state <= cpw_pkg::ST_IDLE;
          end
        end
        cpw_pkg::ST_XFER: begin
          if (dma_stb && widx == cpw_pkg::LAST_WORD) begin
            state <= cpw_pkg::ST_PROG;
          end
        end
        cpw_pkg::ST_PROG: begin
          if (prog_done) begin
            // Stop at a failing sector or after the last one [RULE19] [RULE13]
            state <= (prog_err || remaining == 9'h001) ? cpw_pkg::ST_DONE : cpw_pkg::ST_XFER;
          end
        end
        cpw_pkg::ST_DONE: begin
          state <= cpw_pkg::ST_IDLE;
        end
        default: begin
          state <= cpw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ***********************************************
  // Task file and command register
  // ***********************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tf  <= '{8'h00, cpw_pkg::RST_SECCNT, cpw_pkg::RST_SECNUM, 8'h00, 8'h00, 8'h00};
      cmd <= 8'h00;
    end else begin
      if (tf_wr) begin
        case (addr)
          cpw_pkg::A_ERR_FEAT: tf.feature <= wdata[7:0];
          cpw_pkg::A_SECCNT:   tf.sec_cnt <= wdata[7:0];
          cpw_pkg::A_SECNUM:   tf.sec_num <= wdata[7:0];
          cpw_pkg::A_CYLLO:    tf.cyl_lo  <= wdata[7:0];
          cpw_pkg::A_CYLHI:    tf.cyl_hi  <= wdata[7:0];
          cpw_pkg::A_DRVHD:    tf.drv_hd  <= wdata[7:0];
          cpw_pkg::A_CMD_STAT: cmd        <= wdata[7:0];
          default: begin
          end
        endcase
      end
      if (state == cpw_pkg::ST_PREP && cmd == cpw_pkg::CMD_WEAR && !SECURITY) begin
        tf.sec_cnt <= cpw_pkg::WEAR_NONE; // [RULE10]
      end
      // Advance only between sectors, so the last one stays in place [RULE18]
      if (state == cpw_pkg::ST_PROG && prog_done && !prog_err && remaining != 9'h001) begin
        tf.drv_hd[3:0] <= next_lba[27:24];
        tf.cyl_hi      <= next_lba[23:16];
        tf.cyl_lo      <= next_lba[15:8];
        tf.sec_num     <= next_lba[7:0];
      end
    end
  end

  // ***********************************************
  // Error, interrupt, modes
  // ***********************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_reg <= 8'h00;
    end else if (cmd_wr) begin
      err_reg <= 8'h00;
    end else if (state == cpw_pkg::ST_PREP && abort) begin
      err_reg[cpw_pkg::ER_ABRT] <= 1'b1; // [RULE20]
    end else if (state == cpw_pkg::ST_PROG && prog_done && prog_err) begin
      err_reg[cpw_pkg::ER_MEDIA] <= 1'b1; // [RULE19]
    end
  end

  // Set wins over the status-read clear so no completion is lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intrq <= 1'b0;
    end else if (state == cpw_pkg::ST_DONE ||
                 (state == cpw_pkg::ST_PREP && cmd == cpw_pkg::CMD_TRANSLATE)) begin
      intrq <= 1'b1; // [RULE17] [RULE1] [RULE4]
    end else if (cmd_wr || (re && addr == cpw_pkg::A_CMD_STAT)) begin
      intrq <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byte_mode <= 1'b0;
      frozen    <= 1'b0;
    end else if (state == cpw_pkg::ST_PREP) begin
      if (cmd == cpw_pkg::CMD_SETFEAT && tf.feature == cpw_pkg::FEAT_BYTE_ON) begin
        byte_mode <= 1'b1; // [RULE21]
      end
      if (cmd == cpw_pkg::CMD_SETFEAT && tf.feature == cpw_pkg::FEAT_BYTE_OFF) begin
        byte_mode <= 1'b0; // [RULE21]
      end
      if (cmd == cpw_pkg::CMD_WEAR && SECURITY) begin
        frozen <= 1'b1; // [RULE11]
      end
    end
  end

  // ***********************************************
  // Sleep and idle timer
  // ***********************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt <= 20'h00000;
    end else if (state != cpw_pkg::ST_IDLE || sleeping || we || re || timer_hit) begin
      idle_cnt <= 20'h00000;
    end else begin
      idle_cnt <= idle_cnt + 20'h00001; // [RULE3]
    end
  end

  // Reset also wakes, since the flag clears under rstn [RULE2]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleeping <= 1'b0;
    end else if (state == cpw_pkg::ST_PREP && (is_sleep(cmd) || is_stby(cmd))) begin
      sleeping <= 1'b1; // [RULE1] [RULE4]
    end else if (cmd_wr) begin
      sleeping <= 1'b0; // [RULE2]
    end else if (timer_hit && state == cpw_pkg::ST_IDLE && !we && !re) begin
      sleeping <= 1'b1; // [RULE3]
    end
  end

  // ***********************************************
  // Sector buffer and transfer counters
  // ***********************************************
  always_ff @(posedge clk) begin
    if (store) begin
      sbuf[widx] <= store_word; // [RULE12]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      widx    <= 8'h00;
      bptr    <= 9'h000;
      lo_pend <= 1'b0;
      lo_byte <= 8'h00;
    end else if (state == cpw_pkg::ST_PREP) begin
      widx    <= 8'h00;
      bptr    <= 9'h000;
      lo_pend <= 1'b0;
    end else begin
      if (store) begin
        widx <= widx + 8'h01;
      end
      // Byte mode pairs two data writes, low byte first
      if (pio_wr && byte_mode) begin
        lo_pend <= !lo_pend;
        lo_byte <= wdata[7:0];
      end
      if (pio_rd) begin
        bptr <= bptr + (byte_mode ? 9'h001 : 9'h002);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remaining <= 9'h000;
    end else if (state == cpw_pkg::ST_PREP) begin
      remaining <= (tf.sec_cnt == 8'h00) ? cpw_pkg::FULL_COUNT : {1'b0, tf.sec_cnt}; // [RULE13]
    end else if (state == cpw_pkg::ST_PROG && prog_done) begin
      remaining <= remaining - 9'h001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      iowr_q <= 1'b1;
    end else begin
      iowr_q <= iowr_n;
    end
  end

  // ***********************************************
  // Media program request and buffer readout
  // ***********************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prog <= '0;
    end else begin
      prog.req <= dma_stb && widx == cpw_pkg::LAST_WORD;
      if (dma_stb && widx == cpw_pkg::LAST_WORD) begin
        prog.lba <= lba;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_word <= 16'h0000;
    end else begin
      buf_word <= sbuf[buf_idx];
    end
  end

  // ***********************************************
  // Register read port
  // ***********************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (re) begin
      case (addr)
        cpw_pkg::A_DATA: begin
          if (state != cpw_pkg::ST_PIO_OUT) begin
            rdata <= 16'h0000;
          end else if (byte_mode) begin
            rdata <= {8'h00, tr_byte(bptr, tf, erased, hot_count)};
          end else begin
            rdata <= {tr_byte(bptr + 9'h001, tf, erased, hot_count), tr_byte(bptr, tf, erased, hot_count)};
          end
        end
        cpw_pkg::A_ERR_FEAT: rdata <= {8'h00, err_reg};
        cpw_pkg::A_SECCNT:   rdata <= {8'h00, tf.sec_cnt};
        cpw_pkg::A_SECNUM:   rdata <= {8'h00, tf.sec_num};
        cpw_pkg::A_CYLLO:    rdata <= {8'h00, tf.cyl_lo};
        cpw_pkg::A_CYLHI:    rdata <= {8'h00, tf.cyl_hi};
        cpw_pkg::A_DRVHD:    rdata <= {8'h00, tf.drv_hd};
        default:             rdata <= {8'h00, status};
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ***********************************************
  // Checks
  // ***********************************************
  a_sleep_seq: assert property (@(posedge clk) disable iff (!rstn) // [RULE1]
    cmd_wr && is_sleep(wdata[7:0]) |=> busy ##1 (busy && sleeping) ##1 (!busy && sleeping && intrq))
    else $error("sleep command sequence wrong");
  a_wake_cmd: assert property (@(posedge clk) disable iff (!rstn) // [RULE2]
    sleeping && cmd_wr |=> !sleeping)
    else $error("command did not wake the card");
  a_idle_timer: assert property (@(posedge clk) disable iff (!rstn) // [RULE3]
    timer_hit && state == cpw_pkg::ST_IDLE && !sleeping && !we && !re |=> sleeping)
    else $error("idle timer did not enter sleep");
  a_standby_seq: assert property (@(posedge clk) disable iff (!rstn) // [RULE4]
    cmd_wr && is_stby(wdata[7:0]) |=> busy ##1 sleeping ##1 (!busy && intrq))
    else $error("standby sequence wrong");
  a_erased_byte: assert property (@(posedge clk) disable iff (!rstn) // [RULE7]
    pio_rd && byte_mode && bptr == cpw_pkg::TR_ERASED |=>
      rdata[7:0] == ($past(erased) ? cpw_pkg::ERASED_YES : cpw_pkg::ERASED_NO))
    else $error("erased flag byte wrong");
  a_zero_count: assert property (@(posedge clk) disable iff (!rstn) // [RULE13]
    state == cpw_pkg::ST_PREP && tf.sec_cnt == 8'h00 |=> remaining == cpw_pkg::FULL_COUNT)
    else $error("zero sector count not taken as 256");
  a_dmareq_room: assert property (@(posedge clk) disable iff (!rstn) // [RULE15]
    dmareq |-> !busy && remaining != 9'h000)
    else $error("request while unable to accept");
  a_intr_end: assert property (@(posedge clk) disable iff (!rstn) // [RULE17]
    $rose(intrq) |-> $past(state) == cpw_pkg::ST_DONE || $past(state) == cpw_pkg::ST_PREP)
    else $error("interrupt raised mid transfer");
  a_dma_abort: assert property (@(posedge clk) disable iff (!rstn) // [RULE20]
    cmd_wr && wdata[7:0] == cpw_pkg::CMD_WRDMA && byte_mode |=>
      ##1 (err_reg[cpw_pkg::ER_ABRT] && !dmareq) ##1 intrq)
    else $error("byte mode DMA write not aborted");
  a_err_addr: assert property (@(posedge clk) disable iff (!rstn) // [RULE19]
    state == cpw_pkg::ST_PROG && prog_done && prog_err |=> lba == $past(lba) && !dmareq)
    else $error("address moved after sector error");
endmodule // cpw_core
`default_nettype wire

//--- testbench/cpw_host_dma.sv
/* Host DMA model: strobes one word every other cycle while asked.
   Assumes the card samples on the rising clk edge. */
`timescale 1ns/100ps
`default_nettype none
module cpw_host_dma (
  input  wire logic        clk,
  input  wire logic        dmareq,
  input  wire logic        go,
  output logic             dmack_n,
  output logic             iowr_n,
  output logic      [15:0] dma_data
);
  // One process drives every output, so each has a single driver
  // Strobe high between words so each fall is one word
  initial begin
    dmack_n = 1'b1;
    iowr_n = 1'b1;
    dma_data = 16'h0000;
    forever begin
      @(posedge clk);
      dmack_n <= !(go && dmareq);
      iowr_n <= (go && dmareq) ? ~iowr_n : 1'b1;
      // Data counts up every cycle so stale words never look valid
      dma_data <= dma_data + 16'h0001;
    end
  end
endmodule // cpw_host_dma
`default_nettype wire

//--- testbench/test_card_power_and_write_cmds.sv
/* Bench for the card command executor.
   Assumes cpw_pkg, cpw_core and the host DMA model. */
`timescale 1ns/100ps
`default_nettype none
module test_card_power_and_write_cmds;
  logic clk = 1'b0, rstn = 1'b0, we = 1'b0, re = 1'b0, go = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000, rdata, buf_word, dma_data, v;
  logic intrq, dmareq, dmack_n, iowr_n, sleeping, frozen;
  logic prog_done = 1'b0, prog_err = 1'b0, erased = 1'b1;
  logic [7:0] buf_idx = 8'h05;
  logic [23:0] hot_count = 24'habcdef;
  cpw_pkg::cpw_prog_s prog;
  int err_count = 0, n_checks = 0, cyc = 0, np = 0;
  cpw_core #(.SLEEP_CYCLES(40)) i_dut (.clk, .rstn, .addr, .wdata, .we, .re, .rdata, .intrq,
    .dmareq, .dmack_n, .iowr_n, .dma_data, .sleeping, .frozen, .prog, .prog_done,
    .prog_err, .buf_idx, .buf_word, .erased, .hot_count);
  cpw_host_dma i_host (.clk, .dmareq, .go, .dmack_n, .iowr_n, .dma_data);
  always #10 clk = ~clk;
  // Media answers one cycle after each program request
  always @(posedge clk) begin
    prog_done <= prog.req;
    if (prog.req === 1'b1) np <= np + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [2:0] a, logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic t_sleep;
    logic [7:0] ops [6] = '{8'h99, 8'he6, 8'h96, 8'he2, 8'h94, 8'he0};
    foreach (ops[i]) begin
      wr(3'h7, {8'h00, ops[i]});
      wt(3);
      chk("sleeping", 16'h0001, {15'h0, sleeping});
      chk("intrq", 16'h0001, {15'h0, intrq});
      rd(3'h7);
      chk("busy", 16'h0000, {15'h0, v[cpw_pkg::ST_BSY]});
    end
    wr(3'h7, 16'h00f5);
    wt(4);
    chk("woken", 16'h0000, {15'h0, sleeping});
    rd(3'h2);
    chk("seccnt", 16'h0000, v);
    chk("frozen", 16'h0000, {15'h0, frozen});
    wt(30);
    chk("early", 16'h0000, {15'h0, sleeping});
    wt(15);
    chk("idle", 16'h0001, {15'h0, sleeping});
  endtask
  task automatic t_tr;
    logic [15:0] e;
    wr(3'h5, 16'h0012);
    wr(3'h4, 16'h0034);
    wr(3'h3, 16'h0056);
    wr(3'h6, 16'h00e7);
    wr(3'h7, 16'h0087);
    wt(3);
    for (int i = 0; i < 256; i++) begin
      case (i)
        0, 2: e = 16'h3412;
        1: e = 16'h5607;
        3: e = 16'h0056;
        9: e = 16'hff00;
        12: e = 16'hcdab;
        13: e = 16'h00ef;
        default: e = 16'h0000;
      endcase
      rd(3'h0);
      chk("translate", e, v);
    end
  endtask
  task automatic t_wb;
    wr(3'h7, 16'h00e8);
    wt(2);
    for (int i = 0; i < 256; i++) wr(3'h0, 16'(i * 3));
    wt(3);
    chk("intrq", 16'h0001, {15'h0, intrq});
    chk("buffer", 16'h000f, buf_word);
  endtask
  task automatic t_dma(logic [7:0] n, logic er);
    int n0;
    n0 = np;
    prog_err <= er;
    wr(3'h3, 16'h0040);
    wr(3'h2, {8'h00, n});
    wr(3'h7, 16'h00ca);
    go <= 1'b1;
    // Let the command clear the previous interrupt before polling it
    wt(1);
    for (int i = 0; i < 2000 && intrq !== 1'b1; i++) wt(1);
    go <= 1'b0;
    chk("sectors", er ? 16'h0001 : {8'h00, n}, 16'(np - n0));
    chk("lba", {8'h34, er ? 8'h40 : 8'h3f + n}, prog.lba[15:0]);
    rd(3'h3);
    chk("secnum", {8'h00, er ? 8'h40 : 8'h3f + n}, v);
    rd(3'h1);
    chk("error", {9'h0, er, 6'h0}, v);
  endtask
  task automatic t_byte;
    wr(3'h1, 16'h0001);
    wr(3'h7, 16'h00ef);
    wt(3);
    wr(3'h7, 16'h00ca);
    wt(3);
    chk("dmareq", 16'h0000, {15'h0, dmareq});
    rd(3'h1);
    chk("abort", 16'h0004, v);
    wr(3'h7, 16'h0087);
    wt(3);
    for (int i = 0; i < 512; i++) begin
      rd(3'h0);
      if (i == 19) chk("erased8", 16'h00ff, v);
    end
    wr(3'h1, 16'h0081);
    wr(3'h7, 16'h00ef);
    wt(3);
    t_dma(8'h01, 1'b0);
  endtask
  initial begin
    wt(5);
    rstn <= 1'b1;
    t_sleep();
    t_tr();
    t_wb();
    t_dma(8'h02, 1'b0);
    t_dma(8'h03, 1'b1);
    t_byte();
    finish_test();
  end
endmodule // test_card_power_and_write_cmds
`default_nettype wire
